// [bench/fpec_cpu_model.sv]
`timescale 1ns/10ps
// CPU side of the bus: one request at a time, launched just after a rising edge
module fpec_cpu_model (
  input wire logic mclk_i,
  input wire logic [7:0] rdata_i,
  input wire logic rvalid_i,
  output logic [15:0] addr_o,
  output logic [7:0] wdata_o,
  output logic wr_o,
  output logic rd_o
);
  // Quiet bus at time zero
  initial begin
    addr_o = 16'h0000;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // A released bus shows the inverse of its last value, so stale data never helps
  task automatic release_bus();
    addr_o <= ~addr_o;
    wdata_o <= ~wdata_o;
  endtask

  // One-cycle write strobe, held until the edge that takes it
  task automatic wr_op(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge mclk_i);
    wr_o <= 1'b0;
    release_bus();
  endtask

  // One-cycle read request; waits a bounded time for the answer pulse
  task automatic rd_op(input logic [15:0] a, output logic [7:0] d, output int lat);
    @(posedge mclk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge mclk_i);
    rd_o <= 1'b0;
    release_bus();
    lat = 0;
    d = 8'h00;
    while (lat < 20) begin
      @(posedge mclk_i);
      lat++;
      if (rvalid_i === 1'b1) begin
        d = rdata_i;
        break;
      end
    end
  endtask
endmodule

// [bench/fpec_ctrl_tb.sv]
`timescale 1ns/10ps
// Register and array access sequences with expected values
module fpec_ctrl_tb;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic wr;
  logic rd;
  logic rvalid;
  logic hv_on;
  logic tick;
  logic [7:0] got;
  int lat;
  int ticks;
  int err_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  // Size code, write address inside block, cell inside, cell outside
  logic [1:0] codes [3] = '{2'h3, 2'h2, 2'h1};
  logic [15:0] wa [3] = '{16'h780D, 16'h787F, 16'h7FEE};
  logic [15:0] ina [3] = '{16'h7808, 16'h7840, 16'h7C00};
  logic [15:0] outa [3] = '{16'h7810, 16'h7880, 16'h7BFF};

  // 10 MHz bus clock, well above the 2 MHz floor for pump work
  initial begin
    forever #50 mclk = ~mclk;
  end

  fpec_ctrl dut (.mclk_i(mclk), .rst_i(rst), .bus_addr_i(addr), .bus_wdata_i(wdata),
    .bus_wr_i(wr), .bus_rd_i(rd), .bus_rdata_o(rdata), .bus_rvalid_o(rvalid),
    .hv_on_o(hv_on), .pump_tick_o(tick));
  fpec_cpu_model cpu (.mclk_i(mclk), .rdata_i(rdata), .rvalid_i(rvalid), .addr_o(addr),
    .wdata_o(wdata), .wr_o(wr), .rd_o(rd));

  //////////////////////////////////////////////////////////////////////////////
  // Comparisons and verdict
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk1(input logic g, input logic e);
    chk8({7'h00, g}, {7'h00, e});
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Hang guard, far beyond the four long erase holds
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      err_count++;
      summarize();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Bus shorthands
  task automatic wc(input logic [7:0] d);
    cpu.wr_op(fpec_pkg::CTRL_ADDR, d);
  endtask

  task automatic rc();
    cpu.rd_op(fpec_pkg::CTRL_ADDR, got, lat);
  endtask

  task automatic ra(input logic [15:0] a);
    cpu.rd_op(a, got, lat);
  endtask

  // Full erase procedure; pump ticks counted and margin refused while hv is on
  task automatic erase_blk(input logic div, input logic [1:0] code, input logic [15:0] a);
    wc({1'b0, div, code, 4'h2});
    ra(fpec_pkg::PROTECT_ADDR);
    cpu.wr_op(a, 8'h5A);
    wc({1'b0, div, code, 4'hA});
    @(negedge mclk);
    chk1(hv_on, 1'b1);
    // The first edge still shows the tick register from before high voltage rose
    @(posedge mclk);
    ticks = 0;
    repeat (20) begin
      @(posedge mclk);
      ticks += int'(tick);
    end
    chk8(8'(ticks), div ? 8'h0A : 8'h14);
    wc({1'b0, div, code, 4'hE});
    rc();
    chk8(got, {1'b0, div, code, 4'hA});
    repeat (2100) @(posedge mclk);
    wc({1'b0, div, code, 4'h2});
    repeat (4) @(posedge mclk);
    wc(8'h00);
    repeat (4) @(posedge mclk);
  endtask

  // Program one byte, then check it by margin read, stretched eight cycles
  task automatic prog(input logic [15:0] a, input logic [7:0] d);
    wc(8'h01);
    ra(fpec_pkg::PROTECT_ADDR);
    cpu.wr_op(a, d);
    wc(8'h09);
    wc(8'h01);
    wc(8'h05);
    wc(8'h04);
    ra(a);
    chk8(8'(lat), 8'h09);
    chk8(got, d);
    wc(8'h00);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    rc();
    chk8(got, fpec_pkg::CTRL_RESET);
    chk1(hv_on, 1'b0);
    chk1(tick, 1'b0);
    wc(8'h03);
    rc();
    chk8(got, 8'h00);
    wc(8'h01);
    wc(8'h43);
    rc();
    chk8(got, 8'h41);
    wc(8'h09);
    @(negedge mclk);
    chk1(hv_on, 1'b0);
    wc(8'h00);
    erase_blk(1'b0, fpec_pkg::SIZE_FULL, 16'h7900);
    ra(16'h7800);
    chk8(got, fpec_pkg::ERASED_BYTE);
    ra(16'h7FEE);
    chk8(got, fpec_pkg::ERASED_BYTE);
    ra(16'hFFFF);
    chk8(got, fpec_pkg::ERASED_BYTE);
    chk8(8'(lat), 8'h01);
    ra(16'h0100);
    chk8(got, 8'h00);
    cpu.wr_op(16'h7800, 8'hFF);
    ra(16'h7800);
    chk8(got, 8'h00);
    for (int i = 0; i < 3; i++) begin
      prog(ina[i], 8'hFF);
      prog(outa[i], 8'hFF);
      erase_blk(1'b1, codes[i], wa[i]);
      ra(ina[i]);
      chk8(got, fpec_pkg::ERASED_BYTE);
      ra(outa[i]);
      chk8(got, 8'hFF);
    end
    wc(8'h01);
    ra(fpec_pkg::PROTECT_ADDR);
    cpu.wr_op(16'h7900, 8'h00);
    wc(8'h09);
    @(negedge mclk);
    chk1(hv_on, 1'b1);
    wc(8'h08);
    @(negedge mclk);
    chk1(hv_on, 1'b0);
    rc();
    chk8(got, 8'h00);
    // Guard the top part of the array, then try to erase a row inside it
    prog(fpec_pkg::PROTECT_ADDR, 8'h08);
    ra(fpec_pkg::PROTECT_ADDR);
    chk8(got, 8'h08);
    wc(8'h72);
    ra(fpec_pkg::PROTECT_ADDR);
    cpu.wr_op(16'h7A00, 8'h00);
    rc();
    chk8(got, 8'h70);
    wc(8'h7A);
    @(negedge mclk);
    chk1(hv_on, 1'b0);
    summarize();
  end
endmodule

// [design/fpec_ctrl.sv]
`timescale 1ns/10ps
// Function
// - Erased bits read zero, programmed read one
// - 2031 user, 14 vector, one protect byte
// - One-byte pages, eight-byte rows, row erase minimum
// - High voltage only with select and sequence
// - High voltage runs pump and feeds array
// - Margin cannot set while high voltage on
// - Program and erase never both set
// - Divide select: zero by one, one by two
// - Write inside block latches cared address bits
// - Size bits pick full, half, 64, 8
// - Protect read latched, covered range drops select
// - Margin reads take eight extra cycles
module fpec_ctrl (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [15:0] bus_addr_i,
  input wire logic [7:0] bus_wdata_i,
  input wire logic bus_wr_i,
  input wire logic bus_rd_i,
  output logic [7:0] bus_rdata_o,
  output logic bus_rvalid_o,
  output logic hv_on_o,
  output logic pump_tick_o
);
  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  typedef enum logic [2:0] {
    FPEC_RD_IDLE = 3'b001,
    FPEC_RD_STRETCH = 3'b010,
    FPEC_RD_ANSWER = 3'b100
  } fpec_rd_t;

  logic [7:0] mem [fpec_pkg::ARRAY_BYTES]; // Array cells, no reset
  logic pgm_r, pgm_nxt; // Program select
  logic erase_r, erase_nxt; // Erase select
  logic margin_r, margin_nxt; // Margin-read select
  logic hv_r, hv_nxt; // High-voltage enable
  logic [1:0] size_r, size_nxt; // Erase size {high, low}
  logic div_r, div_nxt; // Pump divide select
  logic [7:0] prot_r, prot_nxt; // Latched protect byte
  logic prot_seen_r, prot_seen_nxt; // Protect byte read since select
  logic addr_seen_r, addr_seen_nxt; // Target address latched
  logic [10:0] tgt_r, tgt_nxt; // Target index
  logic [7:0] data_r, data_nxt; // Program data
  logic done_r, done_nxt; // Program pulse already applied
  logic [10:0] sweep_r, sweep_nxt; // Erase sweep index
  fpec_rd_t rd_r, rd_nxt; // Read answer state
  logic [2:0] cnt_r, cnt_nxt; // Stretch counter
  logic [7:0] rdata_r, rdata_nxt; // Read data
  logic tick_r, tick_nxt; // Pump clock enable out
  logic div_tick; // Raw divider output
  logic [7:0] ctrl_view; // Control register as read
  logic in_array; // Address hits the array
  logic [10:0] idx; // Array index of bus address
  logic rd_go; // Read accepted this cycle
  logic prog_fire; // Apply program pulse
  logic erase_we; // Erase one cell this cycle
  logic violate; // Bus write address, or for erase its whole block, hits protected range

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Index bits not cared for the chosen erase size
  function automatic logic [10:0] free_mask(input logic [1:0] sz);
    logic [10:0] m;
    m = 11'h7FF;
    unique case (sz)
      fpec_pkg::SIZE_FULL: m = 11'h7FF;
      fpec_pkg::SIZE_HALF: m = 11'h3FF;
      fpec_pkg::SIZE_EIGHT_ROWS: m = 11'h03F;
      fpec_pkg::SIZE_ROW: m = 11'h007;
    endcase
    return m;
  endfunction

  // True when span top reaches the lowest protected index
  function automatic logic hits_guard(input logic [7:0] p, input logic [10:0] top);
    logic h;
    h = 1'b0;
    if (p[0]) begin
      h = (top >= fpec_pkg::PROT_FLOOR0);
    end else if (p[1]) begin
      h = (top >= fpec_pkg::PROT_FLOOR1);
    end else if (p[2]) begin
      h = (top >= fpec_pkg::PROT_FLOOR2);
    end else if (p[3]) begin
      h = (top >= fpec_pkg::PROT_FLOOR3);
    end
    return h;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  // User space and vector space share the low index bits
  assign in_array = (bus_addr_i[15:11] == fpec_pkg::USER_SPACE_TOP) ||
                    (bus_addr_i[15:4] == fpec_pkg::VECTOR_SPACE_TOP);
  assign idx = bus_addr_i[10:0]; // One byte per page
  assign rd_go = bus_rd_i && (rd_r == FPEC_RD_IDLE);
  assign ctrl_view = {1'b0, div_r, size_r, hv_r, margin_r, erase_r, pgm_r};
  assign prog_fire = hv_r && pgm_r && !done_r;
  // Whole aligned block, never below a row
  assign erase_we = hv_r && erase_r &&
                    ((sweep_r & ~free_mask(size_r)) == (tgt_r & ~free_mask(size_r)));

  ////////////////////////////////////////////////////////////////////////////
  // Control register and sequence tracking

  // Protect check uses the byte latched by the earlier protect read
  always_comb begin
    violate = 1'b0;
    if (pgm_r) begin
      violate = hits_guard(prot_r, idx);
    end else if (erase_r) begin
      violate = hits_guard(prot_r, idx | free_mask(size_r));
    end
  end

  always_comb begin
    pgm_nxt = pgm_r;
    erase_nxt = erase_r;
    margin_nxt = margin_r;
    hv_nxt = hv_r;
    size_nxt = size_r;
    div_nxt = div_r;
    prot_nxt = prot_r;
    prot_seen_nxt = prot_seen_r;
    addr_seen_nxt = addr_seen_r;
    tgt_nxt = tgt_r;
    data_nxt = data_r;
    if (bus_wr_i && bus_addr_i == fpec_pkg::CTRL_ADDR) begin
      // Both selects asked at once: keep the old pair
      if (!(bus_wdata_i[fpec_pkg::BIT_PGM] && bus_wdata_i[fpec_pkg::BIT_ERASE])) begin
        pgm_nxt = bus_wdata_i[fpec_pkg::BIT_PGM];
        erase_nxt = bus_wdata_i[fpec_pkg::BIT_ERASE];
      end
      size_nxt = {bus_wdata_i[fpec_pkg::BIT_SIZE_HIGH], bus_wdata_i[fpec_pkg::BIT_SIZE_LOW]};
      div_nxt = bus_wdata_i[fpec_pkg::BIT_DIV];
      // Select, protect read and address latch must all precede
      hv_nxt = bus_wdata_i[fpec_pkg::BIT_HV] && (pgm_nxt || erase_nxt) &&
               prot_seen_r && addr_seen_r;
      // Margin falls back to zero while high voltage is on
      margin_nxt = bus_wdata_i[fpec_pkg::BIT_MARGIN] && !hv_r && !hv_nxt;
    end else if (bus_wr_i && in_array && (pgm_r || erase_r)) begin
      tgt_nxt = idx;
      data_nxt = bus_wdata_i;
      addr_seen_nxt = 1'b1;
      if (prot_seen_r && violate) begin
        pgm_nxt = 1'b0;
        erase_nxt = 1'b0;
      end
    end
    // Protect byte is captured whenever it is read
    if (rd_go && bus_addr_i == fpec_pkg::PROTECT_ADDR) begin
      prot_nxt = mem[idx];
      prot_seen_nxt = pgm_r || erase_r;
    end
    // No selected operation: high voltage and sequence state go away
    if (!pgm_nxt && !erase_nxt) begin
      hv_nxt = 1'b0;
      prot_seen_nxt = 1'b0;
      addr_seen_nxt = 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pgm_r <= fpec_pkg::CTRL_RESET[fpec_pkg::BIT_PGM];
      erase_r <= fpec_pkg::CTRL_RESET[fpec_pkg::BIT_ERASE];
      margin_r <= fpec_pkg::CTRL_RESET[fpec_pkg::BIT_MARGIN];
      hv_r <= fpec_pkg::CTRL_RESET[fpec_pkg::BIT_HV];
      size_r <= fpec_pkg::CTRL_RESET[fpec_pkg::BIT_SIZE_HIGH:fpec_pkg::BIT_SIZE_LOW];
      div_r <= fpec_pkg::CTRL_RESET[fpec_pkg::BIT_DIV];
      prot_r <= 8'h00;
      prot_seen_r <= 1'b0;
      addr_seen_r <= 1'b0;
      tgt_r <= 11'h000;
      data_r <= 8'h00;
    end else begin
      pgm_r <= pgm_nxt;
      erase_r <= erase_nxt;
      margin_r <= margin_nxt;
      hv_r <= hv_nxt;
      size_r <= size_nxt;
      div_r <= div_nxt;
      prot_r <= prot_nxt;
      prot_seen_r <= prot_seen_nxt;
      addr_seen_r <= addr_seen_nxt;
      tgt_r <= tgt_nxt;
      data_r <= data_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // High-voltage actions on the array

  // One program pulse per high-voltage period; erase sweeps every cell
  always_comb begin
    done_nxt = hv_r && pgm_r;
    sweep_nxt = (hv_r && erase_r) ? sweep_r + 11'h001 : 11'h000;
    tick_nxt = hv_r && div_tick;
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      done_r <= 1'b0;
      sweep_r <= 11'h000;
      tick_r <= 1'b0;
    end else begin
      done_r <= done_nxt;
      sweep_r <= sweep_nxt;
      tick_r <= tick_nxt;
    end
  end

  // Programming only sets bits; erasing clears them to zero
  always_ff @(posedge mclk_i) begin
    if (prog_fire) begin
      mem[tgt_r] <= mem[tgt_r] | data_r;
    end else if (erase_we) begin
      mem[sweep_r] <= fpec_pkg::ERASED_BYTE;
    end
  end

  fpec_pump_div u_div (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .div2_i(div_r),
    .tick_o(div_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  // Requests in the stretch or answer cycles are ignored, not queued
  always_comb begin
    rd_nxt = rd_r;
    cnt_nxt = cnt_r;
    rdata_nxt = rdata_r;
    unique case (rd_r)
      FPEC_RD_IDLE: begin
        if (rd_go) begin
          if (bus_addr_i == fpec_pkg::CTRL_ADDR) begin
            rdata_nxt = ctrl_view;
          end else if (in_array) begin
            rdata_nxt = mem[idx];
          end else begin
            rdata_nxt = 8'h00;
          end
          // Margin reads stretch
          rd_nxt = (margin_r && in_array) ? FPEC_RD_STRETCH : FPEC_RD_ANSWER;
          cnt_nxt = fpec_pkg::STRETCH_LOAD;
        end
      end
      FPEC_RD_STRETCH: begin
        cnt_nxt = cnt_r - 3'h1;
        if (cnt_r == 3'h0) begin
          rd_nxt = FPEC_RD_ANSWER;
        end
      end
      FPEC_RD_ANSWER: begin
        rd_nxt = FPEC_RD_IDLE;
      end
      default: begin
        rd_nxt = FPEC_RD_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rd_r <= FPEC_RD_IDLE;
      cnt_r <= 3'h0;
      rdata_r <= 8'h00;
    end else begin
      rd_r <= rd_nxt;
      cnt_r <= cnt_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign bus_rdata_o = rdata_r;
  assign bus_rvalid_o = rd_r[2];
  assign hv_on_o = hv_r;
  assign pump_tick_o = tick_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  sequence quiet_eight;
    !bus_rvalid_o [*8];
  endsequence

  select_interlock_a: assert property (!(pgm_r && erase_r))
    else $error("program and erase selected together");
  hv_needs_select_a: assert property ($rose(hv_r) |-> (pgm_r || erase_r) &&
    $past(prot_seen_r) && $past(addr_seen_r))
    else $error("high voltage set out of sequence");
  margin_hv_block_a: assert property (hv_r |-> !margin_r)
    else $error("margin set with high voltage on");
  pump_off_idle_a: assert property (!hv_r |=> !pump_tick_o)
    else $error("pump runs without high voltage");
  pump_div_one_a: assert property (hv_r && !div_r |=> pump_tick_o)
    else $error("pump missed a tick at divide by one");
  pump_div_two_a: assert property (hv_r && div_r && $past(hv_r) && $past(div_r) |=>
    pump_tick_o != $past(pump_tick_o))
    else $error("pump not alternating at divide by two");
  margin_stretch_a: assert property (rd_go && margin_r && in_array |=>
    quiet_eight ##1 bus_rvalid_o)
    else $error("margin read not stretched by eight");
  normal_read_a: assert property (rd_go && !(margin_r && in_array) |=> bus_rvalid_o)
    else $error("normal read answer late");
  erase_clears_a: assert property (erase_we |=> mem[$past(sweep_r)] == 8'h00)
    else $error("erased cell not zero");
  addr_latch_a: assert property (bus_wr_i && in_array && (pgm_r || erase_r) &&
    !violate |=> tgt_r == $past(idx))
    else $error("target address not latched");
  protect_drop_a: assert property (bus_wr_i && in_array && (pgm_r || erase_r) &&
    prot_seen_r && violate |=> !pgm_r && !erase_r && !hv_r)
    else $error("protected range kept its select");
  select_drop_hv_a: assert property ($fell(pgm_r || erase_r) |-> !hv_r)
    else $error("high voltage outlived select");
  reset_clear_a: assert property (disable iff (1'b0) rst_i |=> ctrl_view == 8'h00)
    else $error("control not cleared by reset");
endmodule

// [design/fpec_pkg.sv]
package fpec_pkg;
  // Register map
  localparam logic [15:0] CTRL_ADDR = 16'hFE08; // Operation control register
  localparam logic [15:0] PROTECT_ADDR = 16'hFFF0; // Block-protect byte, part of array
  localparam logic [4:0] USER_SPACE_TOP = 5'h0F; // Address bits 15:11 of user space
  localparam logic [11:0] VECTOR_SPACE_TOP = 12'hFFF; // Address bits 15:4 of vector space

  // Array organisation
  localparam int USER_BYTES = 2031; // User bytes
  localparam int VECTOR_BYTES = 14; // User vector bytes
  localparam int PROTECT_BYTES = 1; // Block-protect byte
  localparam int IDX_W = 11; // Array index width, 2 Kbyte of cells
  localparam int ARRAY_BYTES = 2048; // Cells held, covers all of the above
  localparam int PAGE_BYTES = 1; // Program unit
  localparam int ROW_BYTES = 8; // Smallest erase unit
  localparam logic [7:0] ERASED_BYTE = 8'h00; // Erased bits read as zero

  // Control register bit positions
  localparam int BIT_PGM = 0;
  localparam int BIT_ERASE = 1;
  localparam int BIT_MARGIN = 2;
  localparam int BIT_HV = 3;
  localparam int BIT_SIZE_LOW = 4;
  localparam int BIT_SIZE_HIGH = 5;
  localparam int BIT_DIV = 6;
  localparam logic [7:0] CTRL_RESET = 8'h00; // Nothing selected, divide by one

  // Erase size codes {high, low}
  localparam logic [1:0] SIZE_FULL = 2'h0; // 2 Kbyte
  localparam logic [1:0] SIZE_HALF = 2'h1; // 1 Kbyte
  localparam logic [1:0] SIZE_EIGHT_ROWS = 2'h2; // 64 bytes
  localparam logic [1:0] SIZE_ROW = 2'h3; // 8 bytes

  // Lowest index guarded by each protect bit
  localparam logic [10:0] PROT_FLOOR0 = 11'h000;
  localparam logic [10:0] PROT_FLOOR1 = 11'h080;
  localparam logic [10:0] PROT_FLOOR2 = 11'h100;
  localparam logic [10:0] PROT_FLOOR3 = 11'h200;

  // Margin read stretch
  localparam int MARGIN_EXTRA = 8; // Extra bus cycles
  localparam logic [2:0] STRETCH_LOAD = 3'h7; // Counter load giving eight cycles
endpackage

// [design/fpec_pump_div.sv]
`timescale 1ns/10ps
// Charge-pump clock enable: every cycle, or every other cycle
module fpec_pump_div (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic div2_i,
  output logic tick_o
);
  logic phase_r; // Alternating phase for divide by two
  logic phase_nxt;

  // Phase runs free so a change of divisor takes effect at once
  always_comb begin
    phase_nxt = ~phase_r;
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      phase_r <= 1'b0;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  // Divide select: one gives half rate
  assign tick_o = div2_i ? phase_r : 1'b1;
endmodule
